//--- hw/two_wire_pkg.sv
// Shared constants and types for the two-wire bit-level interface
package two_wire_pkg;
	// Register byte offsets on the register bus
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DATA_OFS = 8'h04;
	localparam logic [7:0] CFG_OFS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register, write side: one-shot command bits
	localparam int CMD_CLR_TX = 7;
	localparam int CMD_IGNORE = 6;
	localparam int CMD_CLR_DATA_READY_FLAG = 5;
	localparam int CMD_CLR_ARB = 4;
	localparam int CMD_CLR_START = 3;
	localparam int CMD_CLR_STOP = 2;
	localparam int CMD_SEND_RSTART = 1;
	localparam int CMD_SEND_STOP = 0;

	// Control register, read side: status bits
	localparam int ST_RX = 7;
	localparam int ST_ATTN = 6;
	localparam int ST_DATA_READY_FLAG = 5;
	localparam int ST_ARB = 4;
	localparam int ST_START = 3;
	localparam int ST_STOP = 2;
	localparam int ST_MASTER = 1;
	localparam int ST_TX_ACTIVE = 0;

	// Data register and configuration register fields
	localparam int DATA_BIT = 7;
	localparam int CFG_SLAVE_EN = 7;
	localparam int CFG_MASTER_REQ = 6;
	localparam int CFG_TIMER_RUN = 4;
	localparam int CFG_PS_HI = 1;
	localparam int CFG_PS_LO = 0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'hD3;

	// Timing: clock period and machine cycle of six clocks
	localparam int CLK_PERIOD_NS = 40;
	localparam logic [2:0] MC_CLKS = 3'h6;
	localparam logic [9:0] TMR_MAX = 10'h3FF;
	localparam logic [3:0] TMR_BASE = 4'h8;

	// Start/stop generation sequence
	typedef enum {C_NONE, C_IS_HOLD, C_RS_LOW, C_RS_HIGH, C_RS_HOLD, C_ST_LOW, C_ST_HIGH, C_ST_HOLD} cond_t;

	// Minimum phase count in machine cycles from the prescale field
	function automatic logic [2:0] min_count(input logic [1:0] sel);
		case (sel)
			2'h2: min_count = 3'h7;
			2'h1: min_count = 3'h6;
			2'h0: min_count = 3'h5;
			default: min_count = 3'h4;
		endcase
	endfunction : min_count

	// Register address decode
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == CTRL_OFS) || (a == DATA_OFS) || (a == CFG_OFS);
	endfunction : is_mapped
endpackage : two_wire_pkg

//--- hw/watch_timer.sv
// Bus-watch timer: minimum SCL phase timing and hung-frame detection
module watch_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic enable,
	input wire logic full_run,
	input wire logic reload,
	input wire logic [1:0] sel,
	// Status
	output logic min_done,
	output logic carry
);
	logic [2:0] pre_r, pre_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	logic carry_r, carry_nxt;
	logic tick;
	logic [3:0] preload;

	assign tick = (pre_r == two_wire_pkg::MC_CLKS - 3'h1);
	assign preload = two_wire_pkg::TMR_BASE - {1'b0, two_wire_pkg::min_count(sel)};

	// Next count; reload restarts the phase so done clears one edge later
	always_comb begin
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		carry_nxt = 1'b0;
		if (!enable) begin
			pre_nxt = 3'h0;
			cnt_nxt = 10'h000;
			done_nxt = 1'b0;
		end else begin
			pre_nxt = tick ? 3'h0 : pre_r + 3'h1;
			if (reload) begin
				cnt_nxt = {7'h00, preload[2:0]};
				done_nxt = 1'b0;
			end else if (tick && full_run) begin
				done_nxt = done_r | (cnt_r[2:0] == 3'h7);
				if (cnt_r == two_wire_pkg::TMR_MAX) begin
					carry_nxt = 1'b1;
					cnt_nxt = 10'h000;
				end else begin
					cnt_nxt = cnt_r + 10'h001;
				end
			end else if (tick && !done_r) begin
				// Upper bits hold, so no hang check in this mode
				cnt_nxt[2:0] = cnt_r[2:0] + 3'h1;
				done_nxt = (cnt_r[2:0] == 3'h7);
			end
		end
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_r <= 3'h0;
			cnt_r <= 10'h000;
			done_r <= 1'b0;
			carry_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			carry_r <= carry_nxt;
		end
	end

	assign min_done = done_r;
	assign carry = carry_r;
endmodule : watch_timer

//--- hw/axil_slave.sv
// AXI4-Lite slave front end turning bus cycles into register strobes
module axil_slave (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address and data
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt, w_s_r, w_s_nxt;
	logic [7:0] aw_a_r, aw_a_nxt, w_d_r, w_d_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_go, rd_go;

	// One write and one read in flight; address and data taken in any order
	assign awready = !aw_v_r && !bvalid_r;
	assign wready = !w_v_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign wr_go = aw_v_r && w_v_r && !bvalid_r;
	assign rd_go = arvalid && arready;
	assign wr_en = wr_go && w_s_r && two_wire_pkg::is_mapped(aw_a_r);
	assign wr_addr = aw_a_r;
	assign wr_data = w_d_r;
	assign rd_en = rd_go && two_wire_pkg::is_mapped(araddr);
	assign rd_addr = araddr;

	// Channel state
	always_comb begin
		aw_v_nxt = aw_v_r;
		aw_a_nxt = aw_a_r;
		w_v_nxt = w_v_r;
		w_d_nxt = w_d_r;
		w_s_nxt = w_s_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (awvalid && awready) begin
			aw_v_nxt = 1'b1;
			aw_a_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_v_nxt = 1'b1;
			w_d_nxt = wdata[7:0];
			w_s_nxt = wstrb[0];
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_go) begin
			aw_v_nxt = 1'b0;
			w_v_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = two_wire_pkg::is_mapped(aw_a_r) ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_SLVERR;
		end
		if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = two_wire_pkg::is_mapped(araddr) ? {24'h000000, rd_data} : 32'h00000000;
			rresp_nxt = two_wire_pkg::is_mapped(araddr) ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_SLVERR;
		end
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_v_r <= 1'b0;
			aw_a_r <= 8'h00;
			w_v_r <= 1'b0;
			w_d_r <= 8'h00;
			w_s_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rresp_r <= 2'h0;
			rdata_r <= 32'h00000000;
		end else begin
			aw_v_r <= aw_v_nxt;
			aw_a_r <= aw_a_nxt;
			w_v_r <= w_v_nxt;
			w_d_r <= w_d_nxt;
			w_s_r <= w_s_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
endmodule : axil_slave

//--- hw/two_wire_bit.sv
// Bit-level two-wire serial interface, master or slave, paced by software
// Overview of operation
// - Data write, repeated-start or stop command sets transmit-active.
// - Data read, clear command or arbitration loss clears transmit-active.
// - SDA pulled low and arbitration loss flagged only while transmit-active.
// - Ignore command mutes slave until next start; stop then may grant mastership.
// - Clear command, data read or data write clears data-ready.
// - Separate clear commands clear arbitration-loss, start-seen and stop-seen flags.
// - Any pending flag holds SCL low until software clears them all.
// - Repeated start: send a 1, then pull SDA low after SCL high minimum.
// - Hardware sends the first start itself; repeated start only used by master.
// - Stop: send a 0, then release SDA after SCL high minimum.
// - New transmit bit reaches SDA only while SCL is low.
// - Timer reloads to eight minus minimum count on each SCL transition.
// - Prescale field picks minimum count 7,6,5,4 and timeout 1023..1020.
// - Minimum SCL phase equals count times six-clock machine cycle.
// - All enables zero and not master disables interface and clears timer, whatever timer-run is.
// - Enabled without timer-run, only three low timer bits count.
// - Enabled with timer-run, full timer runs in frames, cleared by edges.
// - Timer carry resets the interface, releasing SCL, and signals a timeout.
// - Attention reads one whenever any of the four flags is set.
// - SCL rise captures SDA and sets data-ready, except at an idle slave.
// - Master set on request with free bus; cleared by loss or final stop.
module two_wire_bit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite register bus
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Open-drain SCL
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Open-drain SDA
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Hang timeout event
	output logic watch_timeout
);
	logic wr_en, rd_en;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic min_done, carry;
	logic [7:0] cfg_r, cfg_nxt;
	logic scl_q_r, sda_q_r;
	logic data_ready_flag_r, data_ready_flag_nxt, arl_r, arl_nxt, str_r, str_nxt, stp_r, stp_nxt;
	logic tx_active_r, tx_active_nxt, tx_bit_r, tx_bit_nxt, sda_bit_r, sda_bit_nxt;
	logic rx_bit_r, rx_bit_nxt, master_r, master_nxt, busy_r, busy_nxt;
	logic ignore_r, ignore_nxt, mclk_low_r, mclk_low_nxt;
	logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	two_wire_pkg::cond_t cond_r, cond_nxt;
	logic wr_ctrl, wr_dat, wr_cfg, rd_dat;
	logic enabled, idle_slave, attention, attn_nxt, mreq;
	logic scl_rise, scl_fall, start_det, stop_det, tmr_reload, arl_set;
	logic cond_drives_low;

	// Register bus front end
	axil_slave u_bus (
		.clk(clk),
		.rst(rst),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// Bus-watch timer; full count only inside a frame
	watch_timer u_timer (
		.clk(clk),
		.rst(rst),
		.enable(enabled),
		.full_run(cfg_r[two_wire_pkg::CFG_TIMER_RUN] && busy_r),
		.reload(tmr_reload),
		.sel({cfg_r[two_wire_pkg::CFG_PS_HI], cfg_r[two_wire_pkg::CFG_PS_LO]}),
		.min_done(min_done),
		.carry(carry)
	);

	// Register access decode; control writes act only as strobes
	assign wr_ctrl = wr_en && (wr_addr == two_wire_pkg::CTRL_OFS);
	assign wr_dat = wr_en && (wr_addr == two_wire_pkg::DATA_OFS);
	assign wr_cfg = wr_en && (wr_addr == two_wire_pkg::CFG_OFS);
	assign rd_dat = rd_en && (rd_addr == two_wire_pkg::DATA_OFS);

	// Mode and pin events
	assign mreq = cfg_r[two_wire_pkg::CFG_MASTER_REQ];
	assign enabled = cfg_r[two_wire_pkg::CFG_SLAVE_EN] || mreq || master_r;
	assign idle_slave = !master_r && ignore_r;
	assign attention = data_ready_flag_r || arl_r || str_r || stp_r;
	assign scl_rise = scl_in && !scl_q_r;
	assign scl_fall = !scl_in && scl_q_r;
	assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in;
	assign stop_det = scl_in && scl_q_r && !sda_q_r && sda_in;
	assign tmr_reload = scl_rise || scl_fall || start_det || stop_det;
	assign cond_drives_low = (cond_r == two_wire_pkg::C_IS_HOLD) || (cond_r == two_wire_pkg::C_RS_HOLD);

	// Arbitration loss only while transmitting
	assign arl_set = enabled && tx_active_r && (
		(scl_rise && !sda_in && sda_bit_r && !cond_drives_low && (cond_r != two_wire_pkg::C_ST_HOLD)) ||
		(start_det && sda_bit_r && (cond_r == two_wire_pkg::C_NONE)) ||
		(scl_fall && (cond_r == two_wire_pkg::C_RS_HIGH)) ||
		(scl_fall && (cond_r == two_wire_pkg::C_ST_HOLD)));

	// Read data mux
	always_comb begin
		case (rd_addr)
			two_wire_pkg::CTRL_OFS: rd_data = {rx_bit_r, attention, data_ready_flag_r, arl_r, str_r, stp_r, master_r, tx_active_r};
			two_wire_pkg::DATA_OFS: rd_data = {rx_bit_r, 7'h00};
			two_wire_pkg::CFG_OFS: rd_data = cfg_r;
			default: rd_data = 8'h00;
		endcase
	end

	// Flags: the hardware set is applied after the software clear so it wins
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_cfg) begin
			cfg_nxt = wr_data & two_wire_pkg::CFG_WMASK;
		end
		data_ready_flag_nxt = data_ready_flag_r;
		if ((wr_ctrl && wr_data[two_wire_pkg::CMD_CLR_DATA_READY_FLAG]) || wr_dat || rd_dat) begin
			data_ready_flag_nxt = 1'b0;
		end
		if (enabled && scl_rise && !idle_slave) begin
			data_ready_flag_nxt = 1'b1;
		end
		arl_nxt = arl_r;
		str_nxt = str_r;
		stp_nxt = stp_r;
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_CLR_ARB]) begin
			arl_nxt = 1'b0;
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_CLR_START]) begin
			str_nxt = 1'b0;
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_CLR_STOP]) begin
			stp_nxt = 1'b0;
		end
		if (arl_set) begin
			arl_nxt = 1'b1;
		end
		if (enabled && start_det && !idle_slave) begin
			str_nxt = 1'b1;
		end
		if (enabled && stop_det && !idle_slave) begin
			stp_nxt = 1'b1;
		end
		rx_bit_nxt = rx_bit_r;
		if (enabled && scl_rise && !idle_slave) begin
			rx_bit_nxt = sda_in;
		end
		// Transmit-active and the bit to send
		tx_active_nxt = tx_active_r;
		tx_bit_nxt = tx_bit_r;
		if (wr_dat) begin
			tx_active_nxt = 1'b1;
			tx_bit_nxt = wr_data[two_wire_pkg::DATA_BIT];
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_SEND_RSTART]) begin
			tx_active_nxt = 1'b1;
			tx_bit_nxt = 1'b1;
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_SEND_STOP]) begin
			tx_active_nxt = 1'b1;
			tx_bit_nxt = 1'b0;
		end
		if (rd_dat || (wr_ctrl && wr_data[two_wire_pkg::CMD_CLR_TX]) || arl_nxt) begin
			tx_active_nxt = 1'b0;
		end
		// Bit reaches the pin only in the low phase, so an early write is safe
		sda_bit_nxt = scl_in ? sda_bit_r : tx_bit_nxt;
		// Slave muting until next start
		ignore_nxt = ignore_r;
		if (start_det) begin
			ignore_nxt = 1'b0;
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_IGNORE]) begin
			ignore_nxt = 1'b1;
		end
		// Frame tracking
		busy_nxt = busy_r;
		if (start_det) begin
			busy_nxt = 1'b1;
		end
		if (stop_det || !enabled) begin
			busy_nxt = 1'b0;
		end
		// Mastership; a stop seen while ignoring also frees the bus for us
		master_nxt = master_r;
		if (enabled && mreq && !busy_r) begin
			master_nxt = 1'b1;
		end
		if (arl_set || (stop_det && (cond_r == two_wire_pkg::C_ST_HOLD) && !mreq)) begin
			master_nxt = 1'b0;
		end
		// Hang: reset the interface and let SCL go
		if (carry) begin
			data_ready_flag_nxt = 1'b0;
			arl_nxt = 1'b0;
			str_nxt = 1'b0;
			stp_nxt = 1'b0;
			tx_active_nxt = 1'b0;
			ignore_nxt = 1'b0;
			busy_nxt = 1'b0;
			master_nxt = 1'b0;
		end
	end

	// Start and stop generation sequence
	always_comb begin
		cond_nxt = cond_r;
		case (cond_r)
			two_wire_pkg::C_NONE: begin
				// First start of a frame is made here, never by command
				if (master_r && !busy_r && tx_active_r && scl_in && min_done && !tmr_reload) begin
					cond_nxt = two_wire_pkg::C_IS_HOLD;
				end
			end
			two_wire_pkg::C_IS_HOLD, two_wire_pkg::C_RS_HOLD: begin
				if (scl_fall) begin
					cond_nxt = two_wire_pkg::C_NONE;
				end
			end
			two_wire_pkg::C_RS_LOW: begin
				if (scl_rise) begin
					cond_nxt = two_wire_pkg::C_RS_HIGH;
				end
			end
			two_wire_pkg::C_RS_HIGH: begin
				if (min_done && !tmr_reload) begin
					cond_nxt = two_wire_pkg::C_RS_HOLD;
				end
			end
			two_wire_pkg::C_ST_LOW: begin
				if (scl_rise) begin
					cond_nxt = two_wire_pkg::C_ST_HIGH;
				end
			end
			two_wire_pkg::C_ST_HIGH: begin
				if (min_done && !tmr_reload) begin
					cond_nxt = two_wire_pkg::C_ST_HOLD;
				end
			end
			two_wire_pkg::C_ST_HOLD: begin
				if (stop_det) begin
					cond_nxt = two_wire_pkg::C_NONE;
				end
			end
			default: cond_nxt = two_wire_pkg::C_NONE;
		endcase
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_SEND_RSTART] && wr_data[two_wire_pkg::CMD_CLR_DATA_READY_FLAG]) begin
			cond_nxt = two_wire_pkg::C_RS_LOW;
		end
		if (wr_ctrl && wr_data[two_wire_pkg::CMD_SEND_STOP] && wr_data[two_wire_pkg::CMD_CLR_DATA_READY_FLAG]) begin
			cond_nxt = two_wire_pkg::C_ST_LOW;
		end
		if (arl_set || carry || !enabled) begin
			cond_nxt = two_wire_pkg::C_NONE;
		end
	end

	// Pin drive: master clock, low-phase stretch and SDA
	always_comb begin
		mclk_low_nxt = mclk_low_r;
		if (!master_r || !busy_r || carry) begin
			mclk_low_nxt = 1'b0;
		end else if (!mclk_low_r && scl_in && min_done && !tmr_reload &&
				(cond_r != two_wire_pkg::C_RS_HIGH) && (cond_r != two_wire_pkg::C_ST_HIGH) &&
				(cond_r != two_wire_pkg::C_ST_HOLD)) begin
			mclk_low_nxt = 1'b1;
		end else if (mclk_low_r && !scl_in && !tmr_reload && min_done && !attention) begin
			mclk_low_nxt = 1'b0;
		end
		// Stretch only once SCL is low, so the high phase is never cut short
		attn_nxt = data_ready_flag_nxt || arl_nxt || str_nxt || stp_nxt;
		scl_oe_nxt = enabled && !carry && (mclk_low_nxt || (attn_nxt && (!scl_in || scl_oe_r)));
		case (cond_nxt)
			two_wire_pkg::C_IS_HOLD, two_wire_pkg::C_RS_HOLD: sda_oe_nxt = 1'b1;
			two_wire_pkg::C_ST_HOLD: sda_oe_nxt = 1'b0;
			default: sda_oe_nxt = !sda_bit_nxt;
		endcase
		sda_oe_nxt = sda_oe_nxt && tx_active_nxt && enabled;
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_r <= two_wire_pkg::CFG_RST;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			data_ready_flag_r <= 1'b0;
			arl_r <= 1'b0;
			str_r <= 1'b0;
			stp_r <= 1'b0;
			rx_bit_r <= 1'b0;
			tx_active_r <= 1'b0;
			tx_bit_r <= 1'b1;
			sda_bit_r <= 1'b1;
			ignore_r <= 1'b0;
			busy_r <= 1'b0;
			master_r <= 1'b0;
			cond_r <= two_wire_pkg::C_NONE;
			mclk_low_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
			data_ready_flag_r <= data_ready_flag_nxt;
			arl_r <= arl_nxt;
			str_r <= str_nxt;
			stp_r <= stp_nxt;
			rx_bit_r <= rx_bit_nxt;
			tx_active_r <= tx_active_nxt;
			tx_bit_r <= tx_bit_nxt;
			sda_bit_r <= sda_bit_nxt;
			ignore_r <= ignore_nxt;
			busy_r <= busy_nxt;
			master_r <= master_nxt;
			cond_r <= cond_nxt;
			mclk_low_r <= mclk_low_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	// Open-drain outputs only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign watch_timeout = carry;
endmodule : two_wire_bit

//--- test/bus_peer.sv
// Far-side bus party: pull-up resolution of SCL and SDA plus a simple outside master
module bus_peer (
	// Clock
	input wire logic clk,
	// Device pulls
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Resolved pin levels
	output logic scl_in,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_pull = 1'b0;
	logic sda_pull = 1'b0;
	// Pull-ups hold both lines high unless some party pulls low
	assign scl_in = !(scl_oe || scl_pull);
	assign sda_in = !(sda_oe || sda_pull);
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	// SCL rise waits out any stretching by the device
	task automatic rise();
		scl_pull <= 1'b0;
		while (!scl_in) hold(1);
		hold(40);
	endtask : rise
	// Start: SDA falls while SCL is high, then SCL falls
	task automatic start_frame();
		hold(1);
		sda_pull <= 1'b1;
		hold(40);
		scl_pull <= 1'b1;
		hold(40);
	endtask : start_frame
	// One bit: data set during SCL low, then a full clock pulse
	task automatic clock_bit(input logic b);
		hold(1);
		sda_pull <= !b;
		hold(40);
		rise();
		scl_pull <= 1'b1;
		hold(40);
	endtask : clock_bit
	// Stop: SDA rises while SCL is high; only sent while this side is master
	task automatic stop_frame();
		hold(1);
		sda_pull <= 1'b1;
		hold(40);
		rise();
		sda_pull <= 1'b0;
		hold(40);
	endtask : stop_frame
endmodule : bus_peer

//--- test/two_wire_bit_properties.sv
// Port-level assertions for the two-wire interface and its register bus
module two_wire_bit_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Pins and timeout
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic watch_timeout
);
	logic [5:0] hi_cnt_r;
	logic [5:0] hi_cnt_nxt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Saturating count of cycles SCL has stood high
	always_comb begin
		hi_cnt_nxt = hi_cnt_r;
		if (!scl_in) hi_cnt_nxt = 6'h00;
		else if (hi_cnt_r != 6'h3F) hi_cnt_nxt = hi_cnt_r + 6'h01;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) hi_cnt_r <= 6'h00;
		else hi_cnt_r <= hi_cnt_nxt;
	end
	sequence s_released;
		##[1:2] !scl_oe;
	endsequence
	property p_open_drain;
		!scl_out && !sda_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
	// Shortest phase is four machine cycles, 24 clocks; slack covers sync delay
	property p_min_high;
		$past(scl_in) && $rose(scl_oe) |-> hi_cnt_r >= 6'h14;
	endproperty
	a_min_high: assert property (p_min_high) else $error("SCL high phase too short");
	property p_to_pulse;
		watch_timeout |=> !watch_timeout;
	endproperty
	a_to_pulse: assert property (p_to_pulse) else $error("timeout not a pulse");
	property p_to_release;
		watch_timeout |-> s_released;
	endproperty
	a_to_release: assert property (p_to_release) else $error("SCL held after timeout");
	property p_ar_block;
		rvalid |-> !arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
	property p_rdata_zero;
		rvalid |-> rdata[31:8] == 24'h000000;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data upper bits set");
	property p_b_hold;
		bvalid && !bready |=> bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
endmodule : two_wire_bit_checker

bind two_wire_bit two_wire_bit_checker chk_i (.clk(clk), .rst(rst), .bvalid(bvalid), .bready(bready),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .watch_timeout(watch_timeout));

//--- test/testbench.sv
// Register-level bench for the two-wire interface against an outside bus party
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_CTRL = two_wire_pkg::CTRL_OFS;
	localparam logic [7:0] A_DATA = two_wire_pkg::DATA_OFS;
	localparam logic [7:0] A_CFG = two_wire_pkg::CFG_OFS;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, watch_timeout;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;
	always #20 clk = !clk;
	two_wire_bit dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .watch_timeout(watch_timeout));
	bus_peer peer (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// Write: handshakes sampled mid-cycle, where they are settled for the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awready;
			tw = wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk(r, (a > A_CFG) ? two_wire_pkg::RESP_SLVERR : two_wire_pkg::RESP_OKAY);
	endtask : wr
	// Read and compare the masked byte; upper bits must read zero
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic ta, tv;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tv = 1'b0;
		while (!tv) begin
			@(negedge clk);
			ta = arready;
			tv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk(r, (a > A_CFG) ? two_wire_pkg::RESP_SLVERR : two_wire_pkg::RESP_OKAY);
		chk(d & {24'hFFFFFF, m}, {24'h0, e});
	endtask : rd
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask : settle
	// Cycle ceiling; the hang test alone needs about 6100
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(A_CTRL, 8'h7F, 8'h00);
		rd(A_CFG, 8'hFF, two_wire_pkg::CFG_RST);
		wr(A_CFG, 8'hBF);
		rd(A_CFG, 8'hFF, 8'hBF & two_wire_pkg::CFG_WMASK);
		wr(8'h0C, 8'h80);
		rd(8'h0C, 8'hFF, 8'h00);
		$display("registers done");
		wr(A_CFG, 8'h80);
		peer.start_frame();
		settle();
		chk(scl_oe, 1'b1);
		rd(A_CTRL, 8'h7F, 8'h48);
		wr(A_CTRL, 8'h08);
		settle();
		chk(scl_oe, 1'b0);
		peer.clock_bit(1'b1);
		rd(A_CTRL, 8'hFF, 8'hE0);
		rd(A_DATA, 8'hFF, 8'h80);
		rd(A_CTRL, 8'h7F, 8'h00);
		wr(A_DATA, 8'h00);
		rd(A_CTRL, 8'h7F, 8'h01);
		settle();
		chk(sda_oe, 1'b1);
		peer.clock_bit(1'b1);
		rd(A_CTRL, 8'hFF, 8'h61);
		wr(A_CTRL, 8'hA0);
		settle();
		chk(sda_oe, 1'b0);
		$display("slave bits done");
		wr(A_DATA, 8'h80);
		peer.clock_bit(1'b0);
		rd(A_CTRL, 8'h7F, 8'h70);
		wr(A_CTRL, 8'h10);
		rd(A_CTRL, 8'h7F, 8'h60);
		wr(A_CTRL, 8'h20);
		peer.stop_frame();
		rd(A_CTRL, 8'h7F, 8'h64);
		wr(A_CTRL, 8'h24);
		wr(A_CTRL, 8'h40);
		peer.start_frame();
		rd(A_CTRL, 8'h7F, 8'h00);
		$display("arbitration and ignore done");
		wr(A_CFG, 8'h90);
		peer.clock_bit(1'b1);
		n = 0;
		while (!watch_timeout && n < 7000) begin
			@(negedge clk);
			n++;
		end
		chk(n > 6050 && n < 6130, 1'b1);
		settle();
		chk(scl_oe, 1'b0);
		peer.stop_frame();
		wr(A_CTRL, 8'h3C);
		$display("hang timeout done");
		wr(A_CFG, 8'h40);
		rd(A_CTRL, 8'h02, 8'h02);
		wr(A_DATA, 8'h80);
		n = 0;
		while (!scl_oe && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(sda_oe, 1'b1);
		wr(A_CFG, 8'h00);
		wr(A_CTRL, 8'h29);
		repeat (100) @(negedge clk);
		rd(A_CTRL, 8'h06, 8'h04);
		$display("master start done");
		stop_test();
	end
endmodule : testbench
